/* File: rtl/fqd_decoder.sv */
// feature query command decoder with apb register access
//
// What this block does
// RULE1 - a finished image download posts a completion entry to the admin completion queue.
// RULE2 - an image download whose pieces overlap completes with command specific status 14h.
// RULE3 - the same overlap status may flag pieces that break advertised granularity/alignment.
// RULE4 - the query takes operands from the data pointer, dword 10 and dword 14 only.
// RULE5 - dword 11 is read only when the selected feature uses it, otherwise treated reserved.
// RULE6 - the buffer start comes from the 128-bit pointer and is ignored if no data moves.
// RULE7 - select in dword 10 bits 10:08 picks current, default, saved or capabilities.
// RULE8 - bit 4 of the optional command support identify field advertises select support.
// RULE9 - saved select on a feature without saved value behaves as default select.
// RULE10 - the feature identifier is dword 10 bits 07:00.
// RULE11 - with uuid selection supported for the feature, dword 14 carries a uuid index.
// RULE12 - without uuid selection support, dword 14 is not read as a uuid index.
// RULE13 - capabilities select returns dword 0 with saveable, per namespace, changeable bits.
// RULE14 - the uuid index sits in dword 14 bits 06:00, upper bits reserved.
// RULE15 - a reserved select code aborts the query with invalid field status.
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module fqd_decoder #(
   parameter int ADDR_W = 12
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // completion posting towards the admin completion queue
   output logic cpl_valid,
   output logic cpl_is_download,
   output logic [10:0] cpl_status,
   output logic [31:0] cpl_dw0,
   // interrupt
   output logic irq
);
   // ==================================================================
   // register storage
   logic [31:0] ctrl;
   logic [31:0] cdw10;
   logic [31:0] cdw11;
   logic [31:0] cdw14;
   logic [127:0] buf_pointer;
   logic [31:0] feat_cfg;
   logic [31:0] dl_cmd;
   logic [2:0] int_status;
   logic [2:0] int_mask;
   fqd_pkg::fqd_cpl_t cpl;
   fqd_pkg::fqd_state_t state;
   logic [7:0] feature_identifier;
   logic busy;
   logic go_query;
   logic go_dl;
   logic query_done;
   logic dl_done;
   logic err_evt;
   logic [31:0] next_prdata;
   logic known;
   fqd_pkg::fqd_cpl_t next_cpl;

   // apb access strobes: every access completes in its access cycle
   logic wr_en;
   logic rd_en;
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] off);
      hit = (a == ADDR_W'(off));
   endfunction

   // ==================================================================
   // software-written registers; command writes ignored while busy
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= fqd_pkg::CTRL_RESET;
         cdw10 <= 32'h0000_0000;
         cdw11 <= 32'h0000_0000;
         cdw14 <= 32'h0000_0000;
         buf_pointer <= 128'h0;
         feat_cfg <= fqd_pkg::FEAT_CFG_RESET;
         dl_cmd <= 32'h0000_0000;
         int_mask <= 3'h0;
      end else if (wr_en) begin
         if (hit(paddr, fqd_pkg::OFF_CTRL)) ctrl <= pwdata;
         if (hit(paddr, fqd_pkg::OFF_CDW10) && !busy) cdw10 <= pwdata;
         if (hit(paddr, fqd_pkg::OFF_CDW11) && !busy) cdw11 <= pwdata;
         if (hit(paddr, fqd_pkg::OFF_CDW14) && !busy) cdw14 <= pwdata;
         if (hit(paddr, fqd_pkg::OFF_PTR0) && !busy) buf_pointer[31:0] <= pwdata;
         if (hit(paddr, fqd_pkg::OFF_PTR1) && !busy) buf_pointer[63:32] <= pwdata;
         if (hit(paddr, fqd_pkg::OFF_PTR2) && !busy) buf_pointer[95:64] <= pwdata;
         if (hit(paddr, fqd_pkg::OFF_PTR3) && !busy) buf_pointer[127:96] <= pwdata;
         if (hit(paddr, fqd_pkg::OFF_FEAT_CFG)) feat_cfg <= pwdata;
         if (hit(paddr, fqd_pkg::OFF_DL_CMD)) dl_cmd <= pwdata;
         if (hit(paddr, fqd_pkg::OFF_INT_MASK)) int_mask <= pwdata[2:0];
      end
   end

   // go bits in ctrl act as one-shot starts (self-clearing is not needed: edge on write)
   assign go_query = wr_en && hit(paddr, fqd_pkg::OFF_CTRL) && pwdata[fqd_pkg::CTRL_GO_QUERY]
                     && !busy;
   assign go_dl = wr_en && hit(paddr, fqd_pkg::OFF_CTRL) && pwdata[fqd_pkg::CTRL_GO_DL]
                  && !busy && !go_query;
   assign busy = (state != fqd_pkg::ST_IDLE);

   // ==================================================================
   // command decode, combinational from the latched dwords
   always_comb begin
      logic [2:0] sel;
      sel = cdw10[fqd_pkg::SEL_LSB +: 3];
      next_cpl = '0;
      // only pointer, dword 10 and dword 14 are operands; dword 11 only if feature uses it
      next_cpl.buf_ptr = feat_cfg[fqd_pkg::FC_USES_DATA] ? buf_pointer : 128'h0; // RULE4 RULE6
      next_cpl.uuid = feat_cfg[fqd_pkg::FC_UUID_OK] ?
                      cdw14[fqd_pkg::UUID_W-1:0] : '0; // RULE11 RULE12 RULE14
      next_cpl.status = fqd_pkg::ST_SUCCESS;
      next_cpl.sel_used = sel;
      if (!ctrl[fqd_pkg::CTRL_SEL_SUPPORT]) begin
         next_cpl.sel_used = 3'(fqd_pkg::SEL_CURRENT);
      end
      case (next_cpl.sel_used) // RULE7
         3'(fqd_pkg::SEL_CURRENT): begin
            next_cpl.dw0 = feat_cfg[fqd_pkg::FC_USES_DW11] ? cdw11 : 32'h0; // RULE5
         end
         3'(fqd_pkg::SEL_DEFAULT): begin
            next_cpl.dw0 = 32'h0;
         end
         3'(fqd_pkg::SEL_SAVED): begin
            // no saved value or not saveable: act as default
            if (!feat_cfg[fqd_pkg::FC_SAVEABLE] || !feat_cfg[fqd_pkg::FC_HAS_SAVED]) begin
               next_cpl.sel_used = 3'(fqd_pkg::SEL_DEFAULT); // RULE9
            end
            next_cpl.dw0 = 32'h0;
         end
         3'(fqd_pkg::SEL_CAPS): begin
            next_cpl.dw0 = {29'h0, feat_cfg[fqd_pkg::FC_CHANGEABLE],
                            feat_cfg[fqd_pkg::FC_PER_NS],
                            feat_cfg[fqd_pkg::FC_SAVEABLE]}; // RULE13
         end
         default: begin
            next_cpl.dw0 = 32'h0;
            next_cpl.status = fqd_pkg::ST_INVALID_FIELD; // RULE15
            next_cpl.buf_ptr = 128'h0;
         end
      endcase
   end

   // ==================================================================
   // sequencer: idle -> decode -> post for a query, idle -> post for a download, one cycle each
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= fqd_pkg::ST_IDLE;
         cpl <= '0;
         feature_identifier <= 8'h00;
         cpl_valid <= 1'b0;
         cpl_is_download <= 1'b0;
         cpl_status <= 11'h000;
         cpl_dw0 <= 32'h0000_0000;
      end else begin
         cpl_valid <= 1'b0;
         case (state)
            fqd_pkg::ST_IDLE: begin
               if (go_query) begin
                  state <= fqd_pkg::ST_DECODE;
                  cpl_is_download <= 1'b0;
               end else if (go_dl) begin
                  // overlap or granularity break both report code 14h; the flags are taken
                  // from the go write itself, since the stored copy lands on this same edge
                  cpl <= '0;
                  cpl.status <= (pwdata[fqd_pkg::CTRL_DL_OVERLAP] ||
                                 pwdata[fqd_pkg::CTRL_DL_GRAN]) ?
                                fqd_pkg::ST_OVERLAP_RANGE : fqd_pkg::ST_SUCCESS; // RULE2 RULE3
                  cpl_is_download <= 1'b1;
                  state <= fqd_pkg::ST_POST;
               end
            end
            fqd_pkg::ST_DECODE: begin
               cpl <= next_cpl;
               feature_identifier <= cdw10[fqd_pkg::FID_LSB +: 8]; // RULE10
               state <= fqd_pkg::ST_POST;
            end
            fqd_pkg::ST_POST: begin
               cpl_valid <= 1'b1; // RULE1
               cpl_status <= cpl.status;
               cpl_dw0 <= cpl.dw0;
               state <= fqd_pkg::ST_IDLE;
            end
            default: state <= fqd_pkg::ST_IDLE;
         endcase
      end
   end

   // ==================================================================
   // sticky interrupt status; set wins over write-one-to-clear
   assign query_done = (state == fqd_pkg::ST_POST) && !cpl_is_download;
   assign dl_done = (state == fqd_pkg::ST_POST) && cpl_is_download;
   assign err_evt = (state == fqd_pkg::ST_POST) && (cpl.status != fqd_pkg::ST_SUCCESS);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_status <= fqd_pkg::INT_RESET;
      end else begin
         int_status <= (int_status & ~((wr_en && hit(paddr, fqd_pkg::OFF_INT_STATUS)) ?
                        pwdata[2:0] : 3'h0)) | {err_evt, dl_done, query_done};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) irq <= 1'b0;
      else irq <= |(int_status & int_mask);
   end

   // ==================================================================
   // read mux; unmapped addresses read zero with pslverr
   always_comb begin
      next_prdata = 32'h0;
      known = 1'b1;
      if (hit(paddr, fqd_pkg::OFF_CTRL)) next_prdata = ctrl;
      else if (hit(paddr, fqd_pkg::OFF_STATUS)) next_prdata = {31'h0, busy};
      else if (hit(paddr, fqd_pkg::OFF_CDW10)) next_prdata = cdw10;
      else if (hit(paddr, fqd_pkg::OFF_CDW11)) next_prdata = cdw11;
      else if (hit(paddr, fqd_pkg::OFF_CDW14)) next_prdata = cdw14;
      else if (hit(paddr, fqd_pkg::OFF_PTR0)) next_prdata = buf_pointer[31:0];
      else if (hit(paddr, fqd_pkg::OFF_PTR1)) next_prdata = buf_pointer[63:32];
      else if (hit(paddr, fqd_pkg::OFF_PTR2)) next_prdata = buf_pointer[95:64];
      else if (hit(paddr, fqd_pkg::OFF_PTR3)) next_prdata = buf_pointer[127:96];
      else if (hit(paddr, fqd_pkg::OFF_FEAT_CFG)) next_prdata = feat_cfg;
      else if (hit(paddr, fqd_pkg::OFF_CPL_DW0)) next_prdata = cpl.dw0;
      else if (hit(paddr, fqd_pkg::OFF_CPL_STS)) begin
         next_prdata = {8'h0, feature_identifier, 2'h0, cpl.sel_used, cpl.status}; // RULE10
      end
      else if (hit(paddr, fqd_pkg::OFF_CPL_PTR0)) next_prdata = cpl.buf_ptr[31:0];
      else if (hit(paddr, fqd_pkg::OFF_CPL_PTR1)) next_prdata = cpl.buf_ptr[63:32];
      else if (hit(paddr, fqd_pkg::OFF_CPL_PTR2)) next_prdata = cpl.buf_ptr[95:64];
      else if (hit(paddr, fqd_pkg::OFF_CPL_PTR3)) next_prdata = cpl.buf_ptr[127:96];
      else if (hit(paddr, fqd_pkg::OFF_CPL_UUID)) next_prdata = {25'h0, cpl.uuid};
      else if (hit(paddr, fqd_pkg::OFF_INT_STATUS)) next_prdata = {29'h0, int_status};
      else if (hit(paddr, fqd_pkg::OFF_INT_MASK)) next_prdata = {29'h0, int_mask};
      else if (hit(paddr, fqd_pkg::OFF_IDENT)) begin
         next_prdata[fqd_pkg::IDENT_SEL_BIT] = ctrl[fqd_pkg::CTRL_SEL_SUPPORT]; // RULE8
      end
      else if (hit(paddr, fqd_pkg::OFF_DL_CMD)) next_prdata = dl_cmd;
      else known = 1'b0;
   end

   // apb answer registered: pready rises with the first cycle of the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !known;
         if (rd_en || (psel && !penable && !pwrite)) prdata <= next_prdata;
      end
   end
endmodule
`default_nettype wire

/* File: rtl/fqd_pkg.sv */
// package for the feature query command decoder: offsets, fields, codes, types
package fqd_pkg;
   // ==================================================================
   // register offsets (byte addresses)
   localparam logic [11:0] OFF_CTRL = 12'h000;
   localparam logic [11:0] OFF_STATUS = 12'h004;
   localparam logic [11:0] OFF_CDW10 = 12'h008;
   localparam logic [11:0] OFF_CDW11 = 12'h00c;
   localparam logic [11:0] OFF_CDW14 = 12'h010;
   localparam logic [11:0] OFF_PTR0 = 12'h014;
   localparam logic [11:0] OFF_PTR1 = 12'h018;
   localparam logic [11:0] OFF_PTR2 = 12'h01c;
   localparam logic [11:0] OFF_PTR3 = 12'h020;
   localparam logic [11:0] OFF_FEAT_CFG = 12'h024;
   localparam logic [11:0] OFF_CPL_DW0 = 12'h028;
   localparam logic [11:0] OFF_CPL_STS = 12'h02c;
   localparam logic [11:0] OFF_CPL_PTR0 = 12'h030;
   localparam logic [11:0] OFF_CPL_PTR1 = 12'h034;
   localparam logic [11:0] OFF_CPL_PTR2 = 12'h038;
   localparam logic [11:0] OFF_CPL_PTR3 = 12'h03c;
   localparam logic [11:0] OFF_CPL_UUID = 12'h040;
   localparam logic [11:0] OFF_INT_STATUS = 12'h044;
   localparam logic [11:0] OFF_INT_MASK = 12'h048;
   localparam logic [11:0] OFF_IDENT = 12'h04c;
   localparam logic [11:0] OFF_DL_CMD = 12'h050;
   // ==================================================================
   // control register bits
   localparam int CTRL_GO_QUERY = 0;
   localparam int CTRL_GO_DL = 1;
   localparam int CTRL_DL_OVERLAP = 2;
   localparam int CTRL_DL_GRAN = 3;
   localparam int CTRL_SEL_SUPPORT = 4;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0010;
   // command dword 10 fields
   localparam int SEL_LSB = 8;
   localparam int FID_LSB = 0;
   // command dword 14 uuid index field width
   localparam int UUID_W = 7;
   // feature configuration register bits
   localparam int FC_SAVEABLE = 0;
   localparam int FC_PER_NS = 1;
   localparam int FC_CHANGEABLE = 2;
   localparam int FC_HAS_SAVED = 3;
   localparam int FC_UUID_OK = 4;
   localparam int FC_USES_DATA = 5;
   localparam int FC_USES_DW11 = 6;
   localparam logic [31:0] FEAT_CFG_RESET = 32'h0000_0000;
   // identify: optional command support bit advertising select
   localparam int IDENT_SEL_BIT = 4;
   // interrupt status bits
   localparam int INT_QUERY_DONE = 0;
   localparam int INT_DL_DONE = 1;
   localparam int INT_ERROR = 2;
   localparam logic [2:0] INT_RESET = 3'h0;
   // ==================================================================
   // status codes: {type[2:0], code[7:0]}
   localparam logic [10:0] ST_SUCCESS = 11'h000;
   localparam logic [10:0] ST_INVALID_FIELD = 11'h002;
   localparam logic [10:0] ST_OVERLAP_RANGE = 11'h114;
   // select codes
   typedef enum logic [2:0] {
      SEL_CURRENT = 3'b000,
      SEL_DEFAULT = 3'b001,
      SEL_SAVED = 3'b010,
      SEL_CAPS = 3'b011
   } fqd_sel_t;
   // decoded command travels as one bundle
   typedef struct packed {
      logic [127:0] buf_ptr;
      logic [31:0] dw0;
      logic [10:0] status;
      logic [UUID_W-1:0] uuid;
      logic [2:0] sel_used;
   } fqd_cpl_t;
   // decoder state
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_DECODE = 2'b01,
      ST_POST = 2'b10
   } fqd_state_t;
endpackage

/* File: tb/fqd_decoder_assertions.sv */
// concurrent checks on the feature query decoder ports
`timescale 1ns/1ps
`default_nettype none
module fqd_decoder_assertions #(
   parameter int ADDR_W = 12
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // completion and interrupt
   input wire logic cpl_valid,
   input wire logic cpl_is_download,
   input wire logic [10:0] cpl_status,
   input wire logic [31:0] cpl_dw0,
   input wire logic irq
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic wr_ctrl;
   logic pend;
   logic [2:0] sel_q;
   logic go_q;
   logic go_d;
   // ==================================================================
   // helper: accepted go writes, outstanding command, last select code
   assign wr_ctrl = psel && penable && pready && pwrite && (paddr == ADDR_W'(fqd_pkg::OFF_CTRL));
   assign go_q = wr_ctrl && !pend && pwdata[0];
   assign go_d = wr_ctrl && !pend && (pwdata[1:0] == 2'b10);
   // a go while busy is ignored, so it must not restart the tracking
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend <= 1'b0;
      end else if (cpl_valid) begin
         pend <= 1'b0;
      end else if (go_q || go_d) begin
         pend <= 1'b1;
      end
   end
   // select as the decoder sees it: cdw10 writes while busy are dropped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_q <= 3'h0;
      end else if (psel && penable && pready && pwrite && !pend &&
                   (paddr == ADDR_W'(fqd_pkg::OFF_CDW10))) begin
         sel_q <= pwdata[10:8];
      end
   end
   // ==================================================================
   // properties
   property p_pready_setup;
      psel && !penable |=> pready;
   endproperty
   property p_pready_pulse;
      pready |=> !pready;
   endproperty
   property p_err_in_access;
      pslverr |-> pready;
   endproperty
   property p_query_lat;
      go_q |-> ##3 cpl_valid && !cpl_is_download;
   endproperty
   property p_dl_lat;
      go_d |-> ##2 cpl_valid && cpl_is_download;
   endproperty
   property p_overlap;
      go_d && (pwdata[2] || pwdata[3]) |-> ##2 cpl_status == fqd_pkg::ST_OVERLAP_RANGE;
   endproperty
   property p_dl_ok;
      go_d && !pwdata[2] && !pwdata[3] |-> ##2 cpl_status == fqd_pkg::ST_SUCCESS;
   endproperty
   property p_rsv_sel;
      go_q && pwdata[4] && sel_q[2] |->
         ##3 cpl_status == fqd_pkg::ST_INVALID_FIELD && cpl_dw0 == 32'h0;
   endproperty
   property p_cpl_cause;
      cpl_valid |-> pend ##1 !cpl_valid;
   endproperty
   property p_irq_cause;
      $rose(irq) |-> $past(cpl_valid) || $past(psel && penable && pwrite, 2);
   endproperty
   a_pready_setup: assert property (p_pready_setup) else $error("no wait-free apb answer");
   a_pready_pulse: assert property (p_pready_pulse) else $error("pready longer than one cycle");
   a_err_in_access: assert property (p_err_in_access) else $error("pslverr outside access");
   a_query_lat: assert property (p_query_lat) else $error("query completion late");
   a_dl_lat: assert property (p_dl_lat) else $error("download completion missing");
   a_overlap: assert property (p_overlap) else $error("overlap status missing");
   a_dl_ok: assert property (p_dl_ok) else $error("clean download not successful");
   a_rsv_sel: assert property (p_rsv_sel) else $error("reserved select not refused");
   a_cpl_cause: assert property (p_cpl_cause) else $error("completion without command");
   a_irq_cause: assert property (p_irq_cause) else $error("irq rose without cause");
   // main scenarios reached
   c_query: cover property (go_q);
   c_overlap: cover property (go_d && pwdata[2]);
   c_irq: cover property (irq);
endmodule
bind fqd_decoder fqd_decoder_assertions #(.ADDR_W(ADDR_W)) fqd_decoder_assertions_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .cpl_valid(cpl_valid), .cpl_is_download(cpl_is_download), .cpl_status(cpl_status),
   .cpl_dw0(cpl_dw0), .irq(irq));
`default_nettype wire

/* File: tb/fqd_host_model.sv */
// host side sink that consumes completion entries posted by the decoder
`timescale 1ns/1ps
`default_nettype none
module fqd_host_model (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // completion entries from the decoder
   input wire logic cpl_valid,
   input wire logic cpl_is_download,
   input wire logic [10:0] cpl_status,
   input wire logic [31:0] cpl_dw0,
   // what the host has seen
   output logic [15:0] cpl_count,
   output logic [10:0] last_status,
   output logic [31:0] last_dw0,
   output logic last_dl
);
   // the strobe stands one cycle, so the entry is taken in that cycle only;
   // reset values differ from any real entry so a stale one never passes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpl_count <= 16'h0;
         last_status <= 11'h7ff;
         last_dw0 <= 32'hffff_ffff;
         last_dl <= 1'b0;
      end else if (cpl_valid) begin
         cpl_count <= cpl_count + 16'h1;
         last_status <= cpl_status;
         last_dw0 <= cpl_dw0;
         last_dl <= cpl_is_download;
      end
   end
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench for the feature query decoder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   typedef struct packed {
      logic [31:0] cdw10;
      logic [31:0] cdw11;
      logic [6:0] cfg;
      logic [10:0] st;
      logic [2:0] sl;
      logic [31:0] dw0;
   } fqd_row_t;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, cpl_valid, cpl_is_download, irq, hdl, e;
   logic [10:0] cpl_status, hst;
   logic [31:0] cpl_dw0, hdw0, r;
   logic [15:0] hcnt;
   int fails = 0;
   int compares = 0;
   fqd_row_t rows [9] = '{
      '{32'h0000_0007, 32'h1234_5678, 7'h40, 11'h000, 3'h0, 32'h1234_5678},
      '{32'hfff8_0003, 32'h0000_dead, 7'h00, 11'h000, 3'h0, 32'h0},
      '{32'h0000_0102, 32'h0000_0055, 7'h40, 11'h000, 3'h1, 32'h0},
      '{32'h0000_0204, 32'h0, 7'h01, 11'h000, 3'h1, 32'h0},
      '{32'h0000_0204, 32'h0, 7'h09, 11'h000, 3'h2, 32'h0},
      '{32'h0000_0305, 32'h0, 7'h07, 11'h000, 3'h3, 32'h7},
      '{32'h0000_0305, 32'h0, 7'h02, 11'h000, 3'h3, 32'h2},
      '{32'h0000_0405, 32'h0, 7'h07, 11'h002, 3'h4, 32'h0},
      '{32'h0000_0705, 32'h0, 7'h07, 11'h002, 3'h7, 32'h0}};
   fqd_decoder fqd_decoder_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cpl_valid(cpl_valid), .cpl_is_download(cpl_is_download),
      .cpl_status(cpl_status), .cpl_dw0(cpl_dw0), .irq(irq));
   fqd_host_model fqd_host_model_i (.pclk(pclk), .presetn(presetn), .cpl_valid(cpl_valid),
      .cpl_is_download(cpl_is_download), .cpl_status(cpl_status), .cpl_dw0(cpl_dw0),
      .cpl_count(hcnt), .last_status(hst), .last_dw0(hdw0), .last_dl(hdl));
   // ==================================================================
   // clock and tasks
   initial begin
      forever #5 pclk = ~pclk;
   end
   // one apb transfer; the request stands until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      r = prdata;
      e = pslverr;
      if (n >= 50) fails++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // start a command and wait, bounded, for the host to see its entry
   task automatic go(input logic [31:0] c);
      logic [15:0] n0;
      n0 = hcnt;
      apb(1'b1, fqd_pkg::OFF_CTRL, c);
      for (int i = 0; i < 20 && hcnt == n0; i++) @(posedge pclk);
      chk({16'h0, hcnt}, {16'h0, n0 + 16'h1});
   endtask
   task automatic wrap_up();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // watchdog well beyond the expected few hundred cycles
   initial begin
      #300000;
      fails++;
      wrap_up();
   end
   // ==================================================================
   // main sequence
   initial begin
      repeat (10) @(posedge pclk);
      chk({28'h0, pready, pslverr, cpl_valid, irq}, 32'h0);
      presetn <= 1'b1;
      apb(1'b0, fqd_pkg::OFF_CTRL, 32'h0);
      chk(r, fqd_pkg::CTRL_RESET);
      apb(1'b0, fqd_pkg::OFF_IDENT, 32'h0);
      chk(r & 32'h10, 32'h10);
      apb(1'b0, 12'hffc, 32'h0);
      chk({r[30:0], e}, 32'h1);
      foreach (rows[i]) begin
         apb(1'b1, fqd_pkg::OFF_CDW10, rows[i].cdw10);
         apb(1'b1, fqd_pkg::OFF_CDW11, rows[i].cdw11);
         apb(1'b1, fqd_pkg::OFF_FEAT_CFG, {25'h0, rows[i].cfg});
         go(32'h11);
         chk(hdw0, rows[i].dw0);
         chk({20'h0, hdl, hst}, {20'h0, 1'b0, rows[i].st});
         apb(1'b0, fqd_pkg::OFF_CPL_STS, 32'h0);
         chk(r, {8'h0, rows[i].cdw10[7:0], 2'h0, rows[i].sl, rows[i].st});
      end
      // select unsupported: the code is ignored and current values come back
      apb(1'b1, fqd_pkg::OFF_CDW10, 32'h0000_0305);
      apb(1'b1, fqd_pkg::OFF_CDW11, 32'h0000_beef);
      apb(1'b1, fqd_pkg::OFF_FEAT_CFG, 32'h47);
      go(32'h01);
      chk(hdw0, 32'h0000_beef);
      apb(1'b0, fqd_pkg::OFF_IDENT, 32'h0);
      chk(r & 32'h10, 32'h0);
      // pointer and uuid index used or ignored as the feature says
      apb(1'b1, fqd_pkg::OFF_CDW10, 32'h0000_0001);
      apb(1'b1, fqd_pkg::OFF_CDW14, 32'hffff_ffa5);
      for (int k = 0; k < 2; k++) begin
         for (int p = 0; p < 4; p++) begin
            apb(1'b1, fqd_pkg::OFF_PTR0 + 12'(4 * p), 32'h1111_1111 * (p + 1));
         end
         apb(1'b1, fqd_pkg::OFF_FEAT_CFG, (k == 0) ? 32'h30 : 32'h0);
         go(32'h11);
         for (int p = 0; p < 4; p++) begin
            apb(1'b0, fqd_pkg::OFF_CPL_PTR0 + 12'(4 * p), 32'h0);
            chk(r, (k == 0) ? 32'h1111_1111 * (p + 1) : 32'h0);
         end
         apb(1'b0, fqd_pkg::OFF_CPL_UUID, 32'h0);
         chk(r, (k == 0) ? 32'h25 : 32'h0);
      end
      // downloads: clean, overlapping, granularity break
      for (int k = 0; k < 3; k++) begin
         go(32'h12 | ((k == 0) ? 32'h0 : 32'h2 << k));
         chk({20'h0, hdl, hst}, {20'h0, 1'b1, (k == 0) ? 11'h000 : 11'h114});
      end
      // interrupt: masked, unmasked, cleared
      apb(1'b1, fqd_pkg::OFF_INT_MASK, 32'h0);
      apb(1'b1, fqd_pkg::OFF_INT_STATUS, 32'h7);
      go(32'h11);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      apb(1'b0, fqd_pkg::OFF_INT_STATUS, 32'h0);
      chk(r, 32'h1);
      apb(1'b1, fqd_pkg::OFF_INT_MASK, 32'h1);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, fqd_pkg::OFF_INT_STATUS, 32'h1);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      // reset in mid-run with the interrupt raised: all returns to its reset state
      go(32'h11);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h1);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk({28'h0, pready, pslverr, cpl_valid, irq}, 32'h0);
      presetn <= 1'b1;
      apb(1'b0, fqd_pkg::OFF_CTRL, 32'h0);
      chk(r, fqd_pkg::CTRL_RESET);
      apb(1'b0, fqd_pkg::OFF_INT_MASK, 32'h0);
      chk(r, 32'h0);
      wrap_up();
   end
endmodule
`default_nettype wire
